//--- bench/clgsc_host_model.sv
// Behavioural host controller driving the landing, run and speed command lines.
// Assumes the bench states its wishes just after a rising core_clk edge.
`timescale 1ns/100ps
module clgsc_host_model (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic landingActive,
	input wire logic wantRun,
	input wire logic wantStart,
	input wire logic [2:0] wantStep,
	input wire logic [31:0] wantPreRamp,
	input wire logic breakHold,
	output logic landingStartCmd,
	output logic [2:0] stepSelect,
	output logic [31:0] preRampSpeed,
	output logic runCmd
);
	// Register the host lines one cycle after the bench asks; step and pre-ramp lines hold while landingActive unless breakHold.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			landingStartCmd <= 1'b0;
			stepSelect <= 3'h0;
			preRampSpeed <= 32'h0000_0000;
			runCmd <= 1'b0;
		end else begin
			runCmd <= wantRun;
			landingStartCmd <= wantStart && wantRun;
			if (!landingActive || breakHold) begin
				preRampSpeed <= wantPreRamp;
				stepSelect <= wantStep;
			end
		end
	end
endmodule

//--- bench/tb.sv
// Self-checking bench for the landing sequencer and gain scheduler.
// Assumes the host model drives the command lines and AXI4-Lite reaches the registers.
`timescale 1ns/100ps
module tb;
	import clgsc_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	clgsc_axi_req_t axiReq = '0;
	clgsc_axi_rsp_t axiRsp;
	logic wantRun = 1'b0, wantStart = 1'b0, breakHold = 1'b0, driveStopped = 1'b0;
	logic [2:0] wantStep = 3'h0, stepSelect;
	logic [31:0] wantPreRamp = '0, finalRefSpeed = '0, detectedSpeed = '0;
	logic [31:0] preRampSpeed, landingSpeedRef, regPropGain, regIntegralTime, rd, prevRef;
	logic signed [31:0] propTorqueRef;
	logic landingStartCmd, runCmd, landingActive, landingAbort, landingDone, highGainSelected;
	logic seen, prevAct = 1'b0;
	logic [1:0] rs;
	logic [31:0] accelSet = 32'h0000_003C;
	logic [31:0] rstExp [11] = '{RST_CTRL, 32'(RST_LAND_DIST), RST_ELEV, RST_NMAX, RST_PGAIN,
		RST_ITIME, RST_PGAIN, RST_ITIME, RST_SW1, RST_SW2, RST_ACCEL};
	int mismatches = 0, testsRun = 0, n;

	// Free-running 20 MHz control clock.
	always #25 core_clk = ~core_clk;

	clgsc_landing_gain dut (.core_clk(core_clk), .sys_rst(sys_rst), .axiReq(axiReq),
		.axiRsp(axiRsp), .landingStartCmd(landingStartCmd), .stepSelect(stepSelect),
		.preRampSpeed(preRampSpeed), .finalRefSpeed(finalRefSpeed),
		.detectedSpeed(detectedSpeed), .runCmd(runCmd), .driveStopped(driveStopped),
		.landingActive(landingActive), .landingSpeedRef(landingSpeedRef),
		.landingAbort(landingAbort), .landingDone(landingDone),
		.highGainSelected(highGainSelected), .regPropGain(regPropGain),
		.regIntegralTime(regIntegralTime), .propTorqueRef(propTorqueRef));

	clgsc_host_model host (.core_clk(core_clk), .sys_rst(sys_rst),
		.landingActive(landingActive), .wantRun(wantRun), .wantStart(wantStart),
		.wantStep(wantStep), .wantPreRamp(wantPreRamp), .breakHold(breakHold),
		.landingStartCmd(landingStartCmd), .stepSelect(stepSelect),
		.preRampSpeed(preRampSpeed), .runCmd(runCmd));

	// Compare one value and count it.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One AXI4-Lite write; the response code lands in rs.
	task automatic axWrite(input logic [7:0] a, input logic [31:0] d);
		axiReq.awvalid <= 1'b1;
		axiReq.awaddr <= a;
		axiReq.wvalid <= 1'b1;
		axiReq.wdata <= d;
		axiReq.wstrb <= 4'hF;
		axiReq.bready <= 1'b1;
		forever begin
			@(posedge core_clk);
			if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
			if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
			if (axiReq.bready && axiRsp.bvalid) begin
				rs = axiRsp.bresp;
				axiReq.bready <= 1'b0;
				break;
			end
		end
		@(posedge core_clk);
	endtask

	// One AXI4-Lite read; data lands in rd and the response code in rs.
	task automatic axRead(input logic [7:0] a);
		axiReq.arvalid <= 1'b1;
		axiReq.araddr <= a;
		axiReq.rready <= 1'b1;
		forever begin
			@(posedge core_clk);
			if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
			if (axiReq.rready && axiRsp.rvalid) begin
				rd = axiRsp.rdata;
				rs = axiRsp.rresp;
				axiReq.rready <= 1'b0;
				break;
			end
		end
		@(posedge core_clk);
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		axRead(a);
		chk(rd, exp);
	endtask

	// Write a value, then read back what the register kept.
	task automatic wrChk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
		axWrite(a, d);
		chk({30'h0, rs}, {30'h0, RESP_OKAY});
		rdChk(a, exp);
	endtask

	// Wait a bounded span for active (0), abort (1) or done (2).
	task automatic waitEv(input int sel, input int lim);
		seen = 1'b0;
		for (n = 0; n < lim && seen !== 1'b1; n++) begin
			@(posedge core_clk);
			seen = (sel == 0) ? landingActive : (sel == 1) ? landingAbort : landingDone;
		end
	endtask

	// Apply a final speed and give the scheduler time to settle.
	task automatic gainAt(input logic [31:0] s, input logic h);
		finalRefSpeed <= s;
		repeat (6) @(posedge core_clk);
		chk({31'h0, highGainSelected}, {31'h0, h});
	endtask

	// Lower the start line long enough to be seen, then raise it.
	task automatic startLand;
		wantStart <= 1'b0;
		repeat (4) @(posedge core_clk);
		wantStart <= 1'b1;
		waitEv(0, 10);
	endtask

	task automatic stopPulse;
		driveStopped <= 1'b1;
		@(posedge core_clk);
		driveStopped <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", testsRun, mismatches);
		if (mismatches == 0 && testsRun > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Each profile step may only fall, and by no more than the limit.
	always @(posedge core_clk) begin
		if (landingActive === 1'b1 && prevAct) begin
			chk({31'h0, landingSpeedRef <= prevRef && prevRef - landingSpeedRef <= accelSet}, 1);
		end
		prevAct <= landingActive === 1'b1;
		prevRef <= landingSpeedRef;
	end

	// Cut a hang short well beyond the expected run length.
	initial begin
		repeat (60000) @(posedge core_clk);
		mismatches++;
		tally_and_finish;
	end

	// Main sequence of register, gain and landing tests.
	initial begin
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		for (int i = 0; i < 11; i++) begin
			rdChk(8'(4 * i), rstExp[i]);
		end
		axRead(8'h30);
		chk({rd[29:0], rs}, {30'h0, RESP_SLVERR});
		axWrite(8'h34, 32'h0000_0005);
		chk({30'h0, rs}, {30'h0, RESP_SLVERR});
		wrChk(OFS_HS_PGAIN, 32'h0000_0000, PGAIN_MIN);
		wrChk(OFS_LS_PGAIN, 32'h0001_0000, PGAIN_MAX);
		wrChk(OFS_HS_ITIME, 32'h0000_1388, ITIME_MAX);
		wrChk(OFS_LS_ITIME, 32'h0000_0000, ITIME_MIN);
		wrChk(OFS_SW_SPEED1, 32'h0006_1A80, SPEED_MAX);
		wrChk(OFS_ELEV_SPEED, 32'h0000_7530, ELEV_MAX);
		$display("test registers finished");
		wrChk(OFS_ELEV_SPEED, 32'h0000_1770, 32'h0000_1770);
		wrChk(OFS_MAX_SPEED, 32'h0000_1770, 32'h0000_1770);
		wrChk(OFS_LAND_DIST, 32'h0000_0001, 32'h0000_0001);
		wrChk(OFS_ACCEL, 32'h0000_003C, 32'h0000_003C);
		wrChk(OFS_HS_PGAIN, 32'h0000_012C, 32'h0000_012C);
		wrChk(OFS_LS_PGAIN, 32'h0000_0064, 32'h0000_0064);
		wrChk(OFS_HS_ITIME, 32'h0000_0014, 32'h0000_0014);
		wrChk(OFS_LS_ITIME, 32'h0000_0028, 32'h0000_0028);
		wrChk(OFS_SW_SPEED1, 32'h0000_03E8, 32'h0000_03E8);
		wrChk(OFS_SW_SPEED2, 32'h0000_01F4, 32'h0000_01F4);
		gainAt(32'h0000_03E9, 1'b1);
		chk(regPropGain, 32'h0000_012C);
		chk(regIntegralTime, 32'h0000_0014);
		gainAt(32'h0000_03E8, 1'b0);
		chk(regPropGain, 32'h0000_0064);
		chk(regIntegralTime, 32'h0000_0028);
		detectedSpeed <= 32'h0000_1770;
		gainAt(32'h0000_0000, 1'b0);
		chk(propTorqueRef, 32'hFFFF_D8F0);
		detectedSpeed <= 32'h0000_0000;
		gainAt(32'h0000_1770, 1'b1);
		chk(propTorqueRef, 32'h0000_7530);
		axWrite(OFS_SW_SPEED2, 32'h0000_07D0);
		gainAt(32'h0000_05DC, 1'b1);
		gainAt(32'h0000_03E7, 1'b0);
		gainAt(32'h0000_05DC, 1'b0);
		gainAt(32'h0000_07D1, 1'b1);
		$display("test gains finished");
		finalRefSpeed <= 32'h0000_2EE0;
		wantRun <= 1'b1;
		startLand;
		chk({31'h0, seen}, 1);
		waitEv(2, 5000);
		chk({31'h0, seen}, 1);
		rdChk(OFS_STATUS, 32'h0001_0004);
		wantPreRamp <= 32'h0000_0005;
		startLand;
		chk({31'h0, seen}, 0);
		wantPreRamp <= 32'h0000_0000;
		axWrite(OFS_LAND_DIST, 32'h0000_0000);
		startLand;
		chk({31'h0, seen}, 0);
		axWrite(OFS_LAND_DIST, 32'h0000_0001);
		$display("test landing finished");
		startLand;
		breakHold <= 1'b1;
		wantPreRamp <= 32'h0000_0005;
		waitEv(1, 6);
		chk({31'h0, seen}, 1);
		finalRefSpeed <= 32'h0000_2EE1;
		repeat (4) @(posedge core_clk);
		chk(landingSpeedRef, finalRefSpeed);
		rdChk(OFS_STATUS, 32'h0001_0006);
		breakHold <= 1'b0;
		wantPreRamp <= 32'h0000_0000;
		startLand;
		chk({31'h0, seen}, 0);
		stopPulse;
		startLand;
		chk({31'h0, seen}, 1);
		wantRun <= 1'b0;
		waitEv(1, 6);
		chk({31'h0, seen}, 1);
		stopPulse;
		axWrite(OFS_ACCEL, 32'h0000_0001);
		accelSet = 32'h0000_0001;
		wantRun <= 1'b1;
		startLand;
		waitEv(1, 3000);
		chk({31'h0, seen}, 1);
		stopPulse;
		$display("test aborts finished");
		axWrite(OFS_CTRL, 32'h0000_0000);
		wantStart <= 1'b0;
		wantStep <= 3'h3;
		repeat (4) @(posedge core_clk);
		wantStep <= 3'h0;
		waitEv(0, 10);
		chk({31'h0, seen}, 1);
		driveStopped <= 1'b1;
		waitEv(2, 4);
		chk({31'h0, seen}, 1);
		driveStopped <= 1'b0;
		$display("test step request finished");
		tally_and_finish;
	end
endmodule

//--- rtl/clgsc_landing_gain.sv
// Creepless landing sequencer and speed regulator gain scheduler with AXI4-Lite registers.
// Assumes all inputs synchronous to core_clk and speeds as unsigned 0.01 r/min magnitudes.
//
// Function
// R01: With the start input mapped, its rising edge requests a landing.
// R02: Unmapped, a step selection change from nonzero to zero requests a landing.
// R03: A landing starts only while the pre-ramp reference speed is zero.
// R04: A landing starts only while the remaining distance is nonzero.
// R05: Landing profile never changes speed by more than the acceleration limit.
// R06: Abort when the profile would not reach zero within the distance.
// R07: Abort when the pre-ramp reference speed becomes nonzero.
// R08: Abort when the run command drops.
// R09: After abort, run on with ordinary speed control and no trip.
// R10: After abort, block new landings until the drive has stopped.
// R11: Host drops the start input once running ends.
// R12: Host holds the pre-ramp speed selection during a landing.
// R13: Host asserts the start input only during deceleration.
// R14: Host places the deceleration point at least the stopping distance early.
// R15: Host should set the start-of-deceleration S-curve to twenty percent or more.
// R16: Regulator uses high or low gain pair by final speed versus switch speeds.
// R17: With speed two not above speed one, go high above speed one.
// R18: Gain 1.00 gives full rated torque for an error of maximum speed.
// R19: Proportional gains are accepted from 0.01 to 200.00.
// R20: Integral times are accepted from 0.001 to 1.000 seconds.
// R21: Switching speeds are accepted from 0.00 to 3600 r/min.
// R22: The profile moves the cage exactly the landing distance, up to 6553.5 mm.
// R23: Elevator speed accepted from 0.01 to 240.00 m/min for distance conversion.
// R24: Remaining distance falls each cycle by the travel at the present speed.
// R25: Completion, abort or stop clears the landing and reloads the distance.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module clgsc_landing_gain (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire clgsc_pkg::clgsc_axi_req_t axiReq,
	output clgsc_pkg::clgsc_axi_rsp_t axiRsp,
	input wire logic landingStartCmd,
	input wire logic [2:0] stepSelect,
	input wire logic [31:0] preRampSpeed,
	input wire logic [31:0] finalRefSpeed,
	input wire logic [31:0] detectedSpeed,
	input wire logic runCmd,
	input wire logic driveStopped,
	output logic landingActive,
	output logic [31:0] landingSpeedRef,
	output logic landingAbort,
	output logic landingDone,
	output logic highGainSelected,
	output logic [31:0] regPropGain,
	output logic [31:0] regIntegralTime,
	output logic signed [31:0] propTorqueRef
);
	import clgsc_pkg::*;

	typedef struct packed {
		clgsc_state_t st;
		logic cmdPrev;
		logic [2:0] stepPrev;
		logic blocked;
		logic landActive;
		logic abortPulse;
		logic donePulse;
		logic [REM_W-1:0] remain;
		logic [31:0] prof;
		logic mapped;
		logic [15:0] landDist;
		logic [31:0] elev;
		logic [31:0] nmax;
		logic [31:0] hsP;
		logic [31:0] hsI;
		logic [31:0] lsP;
		logic [31:0] lsI;
		logic [31:0] sw1;
		logic [31:0] sw2;
		logic [31:0] accel;
		logic highSel;
		logic [31:0] pGain;
		logic [31:0] iTime;
		logic signed [31:0] torqueP;
		logic awHeld;
		logic [7:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		clgsc_axi_rsp_t axi;
	} clgsc_regs_t;

	clgsc_regs_t s_reg;
	clgsc_regs_t s_next;
	logic landReq;
	logic [63:0] stepDist;

	// Limits a written value to its accepted range.
	function automatic logic [31:0] clampv(input logic [31:0] v, input logic [31:0] lo,
		input logic [31:0] hi);
		clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// Merges write data into an old value under the byte strobes.
	function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		mergeStrb = r;
	endfunction

	// Scaled cage travel in one cycle at the given motor speed.
	function automatic logic [63:0] distStep(input logic [31:0] v, input logic [31:0] elv,
		input logic [31:0] nmx);
		logic [127:0] p;
		p = 128'(v) * 128'(elv) * 128'(DIST_K);
		distStep = 64'(p / 128'(nmx));
	endfunction

	// Landing request decode and the travel covered at the present profile speed.
	always_comb begin
		// R01 edge of start input
		// R02 step change to zero
		if (s_reg.mapped) begin
			landReq = landingStartCmd && !s_reg.cmdPrev;
		end else begin
			landReq = (s_reg.stepPrev != 3'b000) && (stepSelect == 3'b000);
		end
		stepDist = distStep(s_reg.prof, s_reg.elev, s_reg.nmax);
	end

	// Next-state logic for the bus slave, the landing sequencer and the gain scheduler.
	always_comb begin
		logic [31:0] wv;
		logic wErr;
		logic signed [65:0] tq;
		logic [127:0] stopLhs;
		logic [127:0] stopRhs;
		logic [REM_W-1:0] fullDist;
		wv = '0;
		wErr = 1'b0;
		tq = '0;
		stopLhs = '0;
		stopRhs = '0;
		s_next = s_reg;
		s_next.abortPulse = 1'b0;
		s_next.donePulse = 1'b0;
		s_next.cmdPrev = landingStartCmd;
		s_next.stepPrev = stepSelect;
		fullDist = {s_reg.landDist, {FRAC_BITS{1'b0}}};

		// Write address and data are taken in either order and held until both are in.
		if (s_reg.axi.awready && axiReq.awvalid) begin
			s_next.awHeld = 1'b1;
			s_next.awAddr = axiReq.awaddr;
		end
		if (s_reg.axi.wready && axiReq.wvalid) begin
			s_next.wHeld = 1'b1;
			s_next.wData = axiReq.wdata;
			s_next.wStrb = axiReq.wstrb;
		end
		if (s_reg.axi.bvalid && axiReq.bready) begin
			s_next.axi.bvalid = 1'b0;
		end
		if (s_next.awHeld && s_next.wHeld && !s_reg.axi.bvalid) begin
			s_next.awHeld = 1'b0;
			s_next.wHeld = 1'b0;
			s_next.axi.bvalid = 1'b1;
			// R19 gain range
			// R20 time range
			// R21 speed range
			// R23 elevator range
			if (s_next.awAddr == OFS_CTRL) begin
				wv = mergeStrb(32'(s_reg.mapped), s_next.wData, s_next.wStrb);
				s_next.mapped = wv[CTRL_MAPPED_BIT];
			end else if (s_next.awAddr == OFS_LAND_DIST) begin
				wv = mergeStrb(32'(s_reg.landDist), s_next.wData, s_next.wStrb);
				s_next.landDist = wv[15:0];
			end else if (s_next.awAddr == OFS_ELEV_SPEED) begin
				wv = mergeStrb(s_reg.elev, s_next.wData, s_next.wStrb);
				s_next.elev = clampv(wv, ELEV_MIN, ELEV_MAX);
			end else if (s_next.awAddr == OFS_MAX_SPEED) begin
				wv = mergeStrb(s_reg.nmax, s_next.wData, s_next.wStrb);
				s_next.nmax = clampv(wv, NMAX_MIN, SPEED_MAX);
			end else if (s_next.awAddr == OFS_HS_PGAIN) begin
				wv = mergeStrb(s_reg.hsP, s_next.wData, s_next.wStrb);
				s_next.hsP = clampv(wv, PGAIN_MIN, PGAIN_MAX);
			end else if (s_next.awAddr == OFS_HS_ITIME) begin
				wv = mergeStrb(s_reg.hsI, s_next.wData, s_next.wStrb);
				s_next.hsI = clampv(wv, ITIME_MIN, ITIME_MAX);
			end else if (s_next.awAddr == OFS_LS_PGAIN) begin
				wv = mergeStrb(s_reg.lsP, s_next.wData, s_next.wStrb);
				s_next.lsP = clampv(wv, PGAIN_MIN, PGAIN_MAX);
			end else if (s_next.awAddr == OFS_LS_ITIME) begin
				wv = mergeStrb(s_reg.lsI, s_next.wData, s_next.wStrb);
				s_next.lsI = clampv(wv, ITIME_MIN, ITIME_MAX);
			end else if (s_next.awAddr == OFS_SW_SPEED1) begin
				wv = mergeStrb(s_reg.sw1, s_next.wData, s_next.wStrb);
				s_next.sw1 = clampv(wv, SPEED_MIN, SPEED_MAX);
			end else if (s_next.awAddr == OFS_SW_SPEED2) begin
				wv = mergeStrb(s_reg.sw2, s_next.wData, s_next.wStrb);
				s_next.sw2 = clampv(wv, SPEED_MIN, SPEED_MAX);
			end else if (s_next.awAddr == OFS_ACCEL) begin
				wv = mergeStrb(s_reg.accel, s_next.wData, s_next.wStrb);
				s_next.accel = clampv(wv, ACCEL_MIN, ACCEL_MAX);
			end else if (s_next.awAddr == OFS_STATUS) begin
				wErr = 1'b0;
			end else begin
				wErr = 1'b1;
			end
			s_next.axi.bresp = wErr ? RESP_SLVERR : RESP_OKAY;
		end
		s_next.axi.awready = !s_next.awHeld && !s_next.axi.bvalid;
		s_next.axi.wready = !s_next.wHeld && !s_next.axi.bvalid;

		// Reads answer one cycle after the address is taken.
		if (s_reg.axi.rvalid && axiReq.rready) begin
			s_next.axi.rvalid = 1'b0;
			s_next.axi.arready = 1'b1;
		end
		if (s_reg.axi.arready && axiReq.arvalid) begin
			s_next.axi.arready = 1'b0;
			s_next.axi.rvalid = 1'b1;
			s_next.axi.rresp = RESP_OKAY;
			if (axiReq.araddr == OFS_CTRL) begin
				s_next.axi.rdata = 32'(s_reg.mapped);
			end else if (axiReq.araddr == OFS_LAND_DIST) begin
				s_next.axi.rdata = 32'(s_reg.landDist);
			end else if (axiReq.araddr == OFS_ELEV_SPEED) begin
				s_next.axi.rdata = s_reg.elev;
			end else if (axiReq.araddr == OFS_MAX_SPEED) begin
				s_next.axi.rdata = s_reg.nmax;
			end else if (axiReq.araddr == OFS_HS_PGAIN) begin
				s_next.axi.rdata = s_reg.hsP;
			end else if (axiReq.araddr == OFS_HS_ITIME) begin
				s_next.axi.rdata = s_reg.hsI;
			end else if (axiReq.araddr == OFS_LS_PGAIN) begin
				s_next.axi.rdata = s_reg.lsP;
			end else if (axiReq.araddr == OFS_LS_ITIME) begin
				s_next.axi.rdata = s_reg.lsI;
			end else if (axiReq.araddr == OFS_SW_SPEED1) begin
				s_next.axi.rdata = s_reg.sw1;
			end else if (axiReq.araddr == OFS_SW_SPEED2) begin
				s_next.axi.rdata = s_reg.sw2;
			end else if (axiReq.araddr == OFS_ACCEL) begin
				s_next.axi.rdata = s_reg.accel;
			end else if (axiReq.araddr == OFS_STATUS) begin
				s_next.axi.rdata = '0;
				s_next.axi.rdata[STAT_ACTIVE_BIT] = s_reg.landActive;
				s_next.axi.rdata[STAT_BLOCKED_BIT] = s_reg.blocked;
				s_next.axi.rdata[STAT_HIGH_BIT] = s_reg.highSel;
				s_next.axi.rdata[31:STAT_REM_LSB] = s_reg.remain[REM_W-1:FRAC_BITS];
			end else begin
				s_next.axi.rdata = '0;
				s_next.axi.rresp = RESP_SLVERR;
			end
		end

		// Landing sequencer.
		case (s_reg.st)
			ST_IDLE: begin
				s_next.remain = fullDist;
				s_next.prof = finalRefSpeed;
				// R03 zero pre-ramp
				// R04 nonzero distance
				if (landReq && runCmd && preRampSpeed == 32'h0000_0000
					&& s_reg.remain != '0) begin
					s_next.st = ST_LAND;
					s_next.landActive = 1'b1;
				end
			end
			ST_LAND: begin
				// Braking distance plus one more held step, so braking starts before the countdown runs short.
				stopLhs = 128'(stepDist) * (128'(s_reg.prof) + 128'(s_reg.accel) * 128'd3);
				stopRhs = 128'(s_reg.remain) * 128'(s_reg.accel) * 128'd2;
				// R07 pre-ramp abort
				// R08 run drop abort
				// R06 overrun abort
				if (!runCmd || preRampSpeed != 32'h0000_0000 || stepDist > 64'(s_reg.remain)
					|| (s_reg.remain == '0 && s_reg.prof != 32'h0000_0000)) begin
					// R09 no trip, plain speed control
					// R10 block until stop
					s_next.st = ST_BLOCK;
					s_next.blocked = 1'b1;
					s_next.landActive = 1'b0;
					s_next.abortPulse = 1'b1;
					s_next.remain = fullDist;
					s_next.prof = finalRefSpeed;
				end else if (s_reg.prof == 32'h0000_0000 || driveStopped) begin
					// R25 clear and reload
					s_next.st = ST_IDLE;
					s_next.landActive = 1'b0;
					s_next.donePulse = 1'b1;
					s_next.remain = fullDist;
				end else begin
					// R24 distance countdown
					// R22 exact travel
					s_next.remain = s_reg.remain - REM_W'(stepDist);
					// R05 bounded deceleration
					if (stopLhs >= stopRhs) begin
						s_next.prof = (s_reg.prof > s_reg.accel) ? s_reg.prof - s_reg.accel : '0;
					end
				end
			end
			ST_BLOCK: begin
				s_next.remain = fullDist;
				s_next.prof = finalRefSpeed;
				if (driveStopped) begin
					s_next.st = ST_IDLE;
					s_next.blocked = 1'b0;
				end
			end
			default: begin
				s_next.st = ST_IDLE;
			end
		endcase

		// R16 gain set choice
		// R17 low second speed
		if (s_reg.sw2 <= s_reg.sw1) begin
			s_next.highSel = finalRefSpeed > s_reg.sw1;
		end else if (finalRefSpeed > s_reg.sw2) begin
			s_next.highSel = 1'b1;
		end else if (finalRefSpeed < s_reg.sw1) begin
			s_next.highSel = 1'b0;
		end
		s_next.pGain = s_reg.highSel ? s_reg.hsP : s_reg.lsP;
		s_next.iTime = s_reg.highSel ? s_reg.hsI : s_reg.lsI;
		// R18 torque scaling
		tq = (($signed({34'd0, finalRefSpeed}) - $signed({34'd0, detectedSpeed}))
			* $signed({34'd0, s_reg.pGain}) * $signed({2'b00, TORQUE_SCALE}))
			/ $signed({34'd0, s_reg.nmax});
		s_next.torqueP = tq[31:0];
	end

	// State register with synchronous reset.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_reg <= '0;
			s_reg.st <= ST_IDLE;
			s_reg.mapped <= RST_CTRL[CTRL_MAPPED_BIT];
			s_reg.landDist <= RST_LAND_DIST;
			s_reg.elev <= RST_ELEV;
			s_reg.nmax <= RST_NMAX;
			s_reg.hsP <= RST_PGAIN;
			s_reg.hsI <= RST_ITIME;
			s_reg.lsP <= RST_PGAIN;
			s_reg.lsI <= RST_ITIME;
			s_reg.sw1 <= RST_SW1;
			s_reg.sw2 <= RST_SW2;
			s_reg.accel <= RST_ACCEL;
			s_reg.pGain <= RST_PGAIN;
			s_reg.iTime <= RST_ITIME;
			s_reg.axi.awready <= 1'b1;
			s_reg.axi.wready <= 1'b1;
			s_reg.axi.arready <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state register.
	assign axiRsp = s_reg.axi;
	assign landingActive = s_reg.landActive;
	assign landingSpeedRef = s_reg.prof;
	assign landingAbort = s_reg.abortPulse;
	assign landingDone = s_reg.donePulse;
	assign highGainSelected = s_reg.highSel;
	assign regPropGain = s_reg.pGain;
	assign regIntegralTime = s_reg.iTime;
	assign propTorqueRef = s_reg.torqueP;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_abortSeen;
		landingAbort && !landingActive && s_reg.blocked;
	endsequence
	sequence s_canStart;
		s_reg.st == ST_IDLE && runCmd && preRampSpeed == 32'h0000_0000 && s_reg.remain != '0;
	endsequence

	property p_startMapped;
		s_canStart and (s_reg.mapped && landingStartCmd && !s_reg.cmdPrev) |=> landingActive;
	endproperty
	a_startMapped: assert property (p_startMapped) else $error("mapped start not taken"); // R01
	property p_startStep;
		s_canStart and (!s_reg.mapped && s_reg.stepPrev != 3'b000 && stepSelect == 3'b000)
			|=> landingActive;
	endproperty
	a_startStep: assert property (p_startStep) else $error("step start not taken"); // R02
	property p_zeroRef;
		$rose(landingActive) |-> $past(preRampSpeed) == 32'h0000_0000;
	endproperty
	a_zeroRef: assert property (p_zeroRef) else $error("start with nonzero reference"); // R03
	property p_distLeft;
		$rose(landingActive) |-> $past(s_reg.remain) != '0;
	endproperty
	a_distLeft: assert property (p_distLeft) else $error("start with no distance"); // R04
	property p_accel;
		landingActive && $past(landingActive) |-> landingSpeedRef <= $past(landingSpeedRef)
			&& $past(landingSpeedRef) - landingSpeedRef <= s_reg.accel;
	endproperty
	a_accel: assert property (p_accel) else $error("profile step above limit"); // R05
	property p_overrun;
		landingActive && runCmd && preRampSpeed == 32'h0000_0000 && stepDist > 64'(s_reg.remain)
			|=> s_abortSeen;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not aborted"); // R06
	property p_refAbort;
		landingActive && preRampSpeed != 32'h0000_0000 |=> s_abortSeen;
	endproperty
	a_refAbort: assert property (p_refAbort) else $error("reference change not aborted"); // R07
	property p_runAbort;
		landingActive && !runCmd |=> s_abortSeen;
	endproperty
	a_runAbort: assert property (p_runAbort) else $error("run drop not aborted"); // R08
	property p_block;
		s_reg.st == ST_BLOCK && !driveStopped |=> !landingActive && s_reg.blocked;
	endproperty
	a_block: assert property (p_block) else $error("landing restarted before stop"); // R10
	property p_highFast;
		s_reg.sw2 <= s_reg.sw1 && finalRefSpeed > s_reg.sw1 |=> highGainSelected ##1
			regPropGain == s_reg.hsP;
	endproperty
	a_highFast: assert property (p_highFast) else $error("high gain not chosen"); // R17
	property p_range;
		s_reg.hsP >= PGAIN_MIN && s_reg.hsP <= PGAIN_MAX && s_reg.lsI <= ITIME_MAX
			&& s_reg.sw2 <= SPEED_MAX;
	endproperty
	a_range: assert property (p_range) else $error("setting out of range"); // R19
endmodule

//--- rtl/clgsc_pkg.sv
// Constants, register map and carrier types for the landing sequencer and gain scheduler.
// Assumes a single 20 MHz control clock and an AXI4-Lite master with 8-bit byte addresses.
package clgsc_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int FRAC_BITS = 40;
	localparam int REM_W = 56;
	// Cage travel per cycle, in 0.1 mm scaled by 2^FRAC_BITS, per unit of speed*elev/nmax.
	localparam logic [63:0] DIST_K = ((64'h0000_0000_0000_0001 << FRAC_BITS)
		* 64'h0000_0000_0000_0064) / (64'h0000_0000_0000_003C * 64'(CLK_HZ));

	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_LAND_DIST = 8'h04;
	localparam logic [7:0] OFS_ELEV_SPEED = 8'h08;
	localparam logic [7:0] OFS_MAX_SPEED = 8'h0C;
	localparam logic [7:0] OFS_HS_PGAIN = 8'h10;
	localparam logic [7:0] OFS_HS_ITIME = 8'h14;
	localparam logic [7:0] OFS_LS_PGAIN = 8'h18;
	localparam logic [7:0] OFS_LS_ITIME = 8'h1C;
	localparam logic [7:0] OFS_SW_SPEED1 = 8'h20;
	localparam logic [7:0] OFS_SW_SPEED2 = 8'h24;
	localparam logic [7:0] OFS_ACCEL = 8'h28;
	localparam logic [7:0] OFS_STATUS = 8'h2C;

	// Field positions.
	localparam int CTRL_MAPPED_BIT = 0;
	localparam int STAT_ACTIVE_BIT = 0;
	localparam int STAT_BLOCKED_BIT = 1;
	localparam int STAT_HIGH_BIT = 2;
	localparam int STAT_REM_LSB = 16;

	// Reset values.
	localparam logic [31:0] RST_CTRL = 32'h0000_0001;
	localparam logic [15:0] RST_LAND_DIST = 16'h0064;
	localparam logic [31:0] RST_ELEV = 32'h0000_1770;
	localparam logic [31:0] RST_NMAX = 32'h0002_BF20;
	localparam logic [31:0] RST_PGAIN = 32'h0000_0064;
	localparam logic [31:0] RST_ITIME = 32'h0000_0064;
	localparam logic [31:0] RST_SW1 = 32'h0000_0000;
	localparam logic [31:0] RST_SW2 = 32'h0000_0000;
	localparam logic [31:0] RST_ACCEL = 32'h0000_0001;

	// Accepted ranges (gain in 0.01, time in ms, speeds in 0.01 r/min or 0.01 m/min).
	localparam logic [31:0] PGAIN_MIN = 32'h0000_0001;
	localparam logic [31:0] PGAIN_MAX = 32'h0000_4E20;
	localparam logic [31:0] ITIME_MIN = 32'h0000_0001;
	localparam logic [31:0] ITIME_MAX = 32'h0000_03E8;
	localparam logic [31:0] SPEED_MIN = 32'h0000_0000;
	localparam logic [31:0] SPEED_MAX = 32'h0005_7E40;
	localparam logic [31:0] ELEV_MIN = 32'h0000_0001;
	localparam logic [31:0] ELEV_MAX = 32'h0000_5DC0;
	localparam logic [31:0] NMAX_MIN = 32'h0000_0001;
	localparam logic [31:0] ACCEL_MIN = 32'h0000_0001;
	localparam logic [31:0] ACCEL_MAX = 32'hFFFF_FFFF;
	localparam logic [63:0] TORQUE_SCALE = 64'h0000_0000_0000_0064;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LAND = 2'b01,
		ST_BLOCK = 2'b10
	} clgsc_state_t;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} clgsc_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} clgsc_axi_rsp_t;
endpackage
